/* File: hw/pscl_strap_latch.sv */
// Strap configuration latch with an AHB-Lite register slave.
// Assumes one 100 MHz clock, hready looped back from hreadyout, word access.
//
// Overview of operation
// - Every strap pin is sampled at the first clock edge after reset release and the levels become the start configuration.
// - Three address straps give a station address from 1 to 7.
// - Interface straps decode 000 as MII, 001 as RMII, 100 as MII with preamble restore, others reserved.
// - The detach strap is loaded into control bit 10, high meaning detached.
// - The speed strap is loaded into control bit 13 and sets the 100 Mbps advertisement.
// - The duplex strap is loaded into control bit 8, high meaning half duplex.
// - The auto-negotiation strap is loaded into control bit 12, high meaning enabled.
// - Strap pins are inputs during reset and turn into outputs afterwards.
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
module pscl_strap_latch #(
  parameter int STRAP_W = pscl_pkg::STRAP_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [STRAP_W-1:0] strap_in,
  output logic [STRAP_W-1:0] strap_out,
  output logic [STRAP_W-1:0] strap_oe_n,
  output logic [2:0] station_addr,
  output logic [1:0] iface_mode,
  output logic detach_mode,
  output logic speed_100,
  output logic duplex_half,
  output logic autoneg_enable
);

  initial begin
    if (STRAP_W != pscl_pkg::STRAP_W) $error("STRAP_W must match layout");
  end

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  logic [STRAP_W-1:0] sampled;
  logic load_pulse;
  logic loaded;

  pscl_strap_capture #(
    .STRAP_W(STRAP_W)
  ) u_capture (
    .hclk(hclk),
    .hresetn(hresetn),
    .strap_in(strap_in),
    .sampled(sampled),
    .load_pulse(load_pulse),
    .loaded(loaded),
    .strap_oe_n(strap_oe_n)
  );

  // ----------------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------------
  logic [2:0] addr_raw;
  logic [2:0] if_raw;
  logic [2:0] addr_dec;
  pscl_pkg::pscl_iface_t if_dec;

  assign addr_raw = sampled[pscl_pkg::STRAP_ADDR_LSB +:
                            pscl_pkg::STRAP_FIELD_W];
  assign if_raw = sampled[pscl_pkg::STRAP_IF_LSB +: pscl_pkg::STRAP_FIELD_W];

  always_comb begin
    // All-zero address straps fall back to the lowest legal address
    if (addr_raw == pscl_pkg::ADDR_ZERO) begin
      addr_dec = pscl_pkg::ADDR_FALLBACK;
    end else begin
      addr_dec = addr_raw;
    end
    case (if_raw)
      pscl_pkg::IF_CODE_MII: if_dec = pscl_pkg::PSCL_IFM_MII;
      pscl_pkg::IF_CODE_RMII: if_dec = pscl_pkg::PSCL_IFM_RMII;
      pscl_pkg::IF_CODE_MII_PR: if_dec = pscl_pkg::PSCL_IFM_MII_PR;
      default: if_dec = pscl_pkg::PSCL_IFM_RSVD;
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------------
  logic take;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic rd_pend_reg;
  logic rd_pend_next;
  logic [11:0] addr_reg;
  logic [11:0] addr_next;
  logic hready_reg;
  logic hready_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  assign take = hsel && hready && (htrans == pscl_pkg::HTRANS_NONSEQ);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] adv_reg;
  logic [15:0] adv_next;
  logic [STRAP_W-1:0] pin_reg;
  logic [STRAP_W-1:0] pin_next;
  logic [2:0] st_addr_reg;
  logic [2:0] st_addr_next;
  logic [2:0] if_raw_reg;
  logic [2:0] if_raw_next;
  logic [1:0] if_mode_reg;
  logic [1:0] if_mode_next;
  logic [31:0] status_word;
  logic [31:0] rd_mux;

  always_comb begin
    status_word = '0;
    status_word[pscl_pkg::ST_ADDR_LSB +: 3] = st_addr_reg;
    status_word[pscl_pkg::ST_IF_RAW_LSB +: 3] = if_raw_reg;
    status_word[pscl_pkg::ST_MODE_LSB +: 2] = if_mode_reg;
    status_word[pscl_pkg::ST_LOADED] = loaded;
    case (addr_reg)
      pscl_pkg::OFS_CTRL: rd_mux = {16'h0000, ctrl_reg};
      pscl_pkg::OFS_ADV: rd_mux = {16'h0000, adv_reg};
      pscl_pkg::OFS_STATUS: rd_mux = status_word;
      pscl_pkg::OFS_PIN: rd_mux = {{(32-STRAP_W){1'b0}}, pin_reg};
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    wr_pend_next = take && hwrite;
    rd_pend_next = take && !hwrite;
    addr_next = take ? haddr[pscl_pkg::DEC_W-1:0] : addr_reg;
    // One wait state on reads so a write just before is seen
    hready_next = !(take && !hwrite);
    hrdata_next = rd_pend_reg ? rd_mux : hrdata_reg;
    ctrl_next = ctrl_reg;
    adv_next = adv_reg;
    pin_next = pin_reg;
    st_addr_next = st_addr_reg;
    if_raw_next = if_raw_reg;
    if_mode_next = if_mode_reg;
    if (load_pulse) begin
      st_addr_next = addr_dec;
      if_raw_next = if_raw;
      if_mode_next = if_dec;
      ctrl_next[pscl_pkg::CTRL_DETACH_BIT] =
        sampled[pscl_pkg::STRAP_DETACH];
      ctrl_next[pscl_pkg::CTRL_SPEED_BIT] =
        sampled[pscl_pkg::STRAP_SPEED];
      ctrl_next[pscl_pkg::CTRL_DUPLEX_BIT] =
        sampled[pscl_pkg::STRAP_DUPLEX];
      ctrl_next[pscl_pkg::CTRL_ANEG_BIT] =
        sampled[pscl_pkg::STRAP_ANEG];
      if (sampled[pscl_pkg::STRAP_SPEED]) begin
        adv_next = pscl_pkg::ADV_RESET;
      end else begin
        adv_next = pscl_pkg::ADV_RESET & ~pscl_pkg::ADV_100_MASK;
      end
    end else if (wr_pend_reg) begin
      case (addr_reg)
        pscl_pkg::OFS_CTRL: begin
          ctrl_next = (ctrl_reg & ~pscl_pkg::CTRL_WMASK) |
                      (hwdata[15:0] & pscl_pkg::CTRL_WMASK);
        end
        pscl_pkg::OFS_ADV: begin
          adv_next = (adv_reg & ~pscl_pkg::ADV_WMASK) |
                     (hwdata[15:0] & pscl_pkg::ADV_WMASK);
        end
        pscl_pkg::OFS_PIN: pin_next = hwdata[STRAP_W-1:0];
        default: pin_next = pin_reg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= '0;
      hready_reg <= 1'b1;
      hrdata_reg <= '0;
      ctrl_reg <= pscl_pkg::CTRL_RESET;
      adv_reg <= pscl_pkg::ADV_RESET;
      pin_reg <= '0;
      st_addr_reg <= pscl_pkg::ADDR_FALLBACK;
      if_raw_reg <= pscl_pkg::IF_CODE_MII;
      if_mode_reg <= pscl_pkg::PSCL_IFM_MII;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      hready_reg <= hready_next;
      hrdata_reg <= hrdata_next;
      ctrl_reg <= ctrl_next;
      adv_reg <= adv_next;
      pin_reg <= pin_next;
      st_addr_reg <= st_addr_next;
      if_raw_reg <= if_raw_next;
      if_mode_reg <= if_mode_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign strap_out = pin_reg;
  assign station_addr = st_addr_reg;
  assign iface_mode = if_mode_reg;
  assign detach_mode = ctrl_reg[pscl_pkg::CTRL_DETACH_BIT];
  assign speed_100 = ctrl_reg[pscl_pkg::CTRL_SPEED_BIT];
  assign duplex_half = ctrl_reg[pscl_pkg::CTRL_DUPLEX_BIT];
  assign autoneg_enable = ctrl_reg[pscl_pkg::CTRL_ANEG_BIT];

endmodule // pscl_strap_latch

/* File: hw/pscl_pkg.sv */
// Constants, field layouts and types for the strap configuration latch.
// Assumes a single 100 MHz clock domain and an AHB-Lite register bus.
package pscl_pkg;

  // ----------------------------------------------------------------------
  // Strap vector layout
  // ----------------------------------------------------------------------
  localparam int STRAP_W = 10;
  localparam int STRAP_ADDR_LSB = 0;
  localparam int STRAP_IF_LSB = 3;
  localparam int STRAP_DETACH = 6;
  localparam int STRAP_SPEED = 7;
  localparam int STRAP_DUPLEX = 8;
  localparam int STRAP_ANEG = 9;
  localparam int STRAP_FIELD_W = 3;

  // ----------------------------------------------------------------------
  // Control register image (register 0h) and advertisement (register 4h)
  // ----------------------------------------------------------------------
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_DETACH_BIT = 10;
  localparam int CTRL_ANEG_BIT = 12;
  localparam int CTRL_SPEED_BIT = 13;
  localparam logic [15:0] CTRL_RESET = 16'h3100;
  localparam logic [15:0] CTRL_WMASK = 16'h3500;
  localparam logic [15:0] ADV_RESET = 16'h01E1;
  localparam logic [15:0] ADV_100_MASK = 16'h0180;
  localparam logic [15:0] ADV_WMASK = 16'h01E0;

  // ----------------------------------------------------------------------
  // Bus map
  // ----------------------------------------------------------------------
  localparam int DEC_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADV = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_PIN = 12'h00C;
  localparam int ST_ADDR_LSB = 0;
  localparam int ST_IF_RAW_LSB = 3;
  localparam int ST_MODE_LSB = 6;
  localparam int ST_LOADED = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------------
  localparam logic [2:0] IF_CODE_MII = 3'h0;
  localparam logic [2:0] IF_CODE_RMII = 3'h1;
  localparam logic [2:0] IF_CODE_MII_PR = 3'h4;
  localparam logic [2:0] ADDR_ZERO = 3'h0;
  localparam logic [2:0] ADDR_FALLBACK = 3'h1;

  typedef enum logic [1:0] {
    PSCL_IFM_MII = 2'b00,
    PSCL_IFM_RMII = 2'b01,
    PSCL_IFM_MII_PR = 2'b10,
    PSCL_IFM_RSVD = 2'b11
  } pscl_iface_t;

  typedef enum logic [1:0] {
    PSCL_CAP_HOLD = 2'b00,
    PSCL_CAP_RUN = 2'b01
  } pscl_cap_state_t;

endpackage

/* File: hw/pscl_strap_capture.sv */
// Strap capture: samples the strap pins at the first edge after reset
// release, then turns the pins round to outputs.
// Assumes strap levels are stable and synchronous to hclk around release.
`timescale 1ns/1ns
module pscl_strap_capture #(
  parameter int STRAP_W = pscl_pkg::STRAP_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [STRAP_W-1:0] strap_in,
  output logic [STRAP_W-1:0] sampled,
  output logic load_pulse,
  output logic loaded,
  output logic [STRAP_W-1:0] strap_oe_n
);

  initial begin
    if (STRAP_W < 1) $error("STRAP_W must be at least 1");
  end

  // ----------------------------------------------------------------------
  // Capture sequencer
  // ----------------------------------------------------------------------
  pscl_pkg::pscl_cap_state_t state_reg;
  pscl_pkg::pscl_cap_state_t state_next;
  logic [STRAP_W-1:0] sampled_reg;
  logic [STRAP_W-1:0] sampled_next;
  logic load_reg;
  logic load_next;
  logic [STRAP_W-1:0] oe_n_reg;
  logic [STRAP_W-1:0] oe_n_next;

  always_comb begin
    state_next = state_reg;
    sampled_next = sampled_reg;
    load_next = 1'b0;
    oe_n_next = oe_n_reg;
    case (state_reg)
      pscl_pkg::PSCL_CAP_HOLD: begin
        sampled_next = strap_in;
        load_next = 1'b1;
        oe_n_next = '0;
        state_next = pscl_pkg::PSCL_CAP_RUN;
      end
      pscl_pkg::PSCL_CAP_RUN: begin
        state_next = pscl_pkg::PSCL_CAP_RUN;
      end
      default: begin
        state_next = pscl_pkg::PSCL_CAP_HOLD;
        oe_n_next = '1;
      end
    endcase
  end

  // Pins stay released (inputs, weak pulls) while reset is active
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= pscl_pkg::PSCL_CAP_HOLD;
      sampled_reg <= '0;
      load_reg <= 1'b0;
      oe_n_reg <= '1;
    end else begin
      state_reg <= state_next;
      sampled_reg <= sampled_next;
      load_reg <= load_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign sampled = sampled_reg;
  assign load_pulse = load_reg;
  assign loaded = (state_reg == pscl_pkg::PSCL_CAP_RUN);
  assign strap_oe_n = oe_n_reg;

endmodule // pscl_strap_capture

/* File: bench/pscl_strap_board.sv */
// Board model: strap resistors and MAC receive inputs on the strap pins.
// Assumes the device drives a pin whenever its active-low enable is 0.
`timescale 1ns/1ns
module pscl_strap_board (
  input wire logic [9:0] strap_level,
  input wire logic [9:0] strap_out,
  input wire logic [9:0] strap_oe_n,
  output logic [9:0] strap_in
);
  // --------------------------------------------------------------------
  // Wire level: resistor while released, device data once driven
  // --------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      strap_in[i] = strap_oe_n[i] ? strap_level[i] : strap_out[i];
    end
  end
endmodule // pscl_strap_board

/* File: bench/pscl_strap_latch_sva.sv */
// Checker on the strap latch top ports.
// Assumes hready is looped back from hreadyout.
`timescale 1ns/1ns
module pscl_strap_latch_sva #(
  parameter int STRAP_W = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [STRAP_W-1:0] strap_in,
  input wire logic [STRAP_W-1:0] strap_oe_n,
  input wire logic [2:0] station_addr,
  input wire logic [1:0] iface_mode,
  input wire logic detach_mode,
  input wire logic speed_100,
  input wire logic duplex_half,
  input wire logic autoneg_enable
);
  // --------------------------------------------------------------------
  // Load and hold checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  function automatic logic [1:0] mode_of(input logic [2:0] c);
    return (c == 3'h0) ? 2'h0 : (c == 3'h1) ? 2'h1 : (c == 3'h4) ? 2'h2 : 2'h3;
  endfunction

  a_pins_turn: assert property ($rose(hresetn) |->
    strap_oe_n == '1 ##1 strap_oe_n == '0) else $error("pin turn wrong");
  a_addr_load: assert property ($rose(hresetn) |=> ##1 station_addr ==
    (($past(strap_in[2:0], 2) == 3'h0) ? 3'h1 : $past(strap_in[2:0], 2)))
    else $error("station address load wrong");
  a_addr_range: assert property (station_addr != 3'h0)
    else $error("station address zero");
  a_iface_load: assert property ($rose(hresetn) |=> ##1
    iface_mode == mode_of($past(strap_in[5:3], 2)))
    else $error("interface decode wrong");
  a_detach_load: assert property ($rose(hresetn) |=> ##1
    detach_mode == $past(strap_in[6], 2))
    else $error("detach load wrong");
  a_speed_load: assert property ($rose(hresetn) |=> ##1
    speed_100 == $past(strap_in[7], 2))
    else $error("speed load wrong");
  a_duplex_load: assert property ($rose(hresetn) |=> ##1
    duplex_half == $past(strap_in[8], 2))
    else $error("duplex load wrong");
  a_aneg_load: assert property ($rose(hresetn) |=> ##1
    autoneg_enable == $past(strap_in[9], 2))
    else $error("autoneg load wrong");
  a_cfg_hold: assert property (
    $past(hresetn) && $past(hresetn, 2) && $past(hresetn, 3) |->
    $stable(station_addr) && $stable(iface_mode) && strap_oe_n == '0)
    else $error("latched strap values moved");
endmodule // pscl_strap_latch_sva

bind pscl_strap_latch pscl_strap_latch_sva #(.STRAP_W(STRAP_W)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .strap_in(strap_in),
  .strap_oe_n(strap_oe_n), .station_addr(station_addr),
  .iface_mode(iface_mode), .detach_mode(detach_mode),
  .speed_100(speed_100), .duplex_half(duplex_half),
  .autoneg_enable(autoneg_enable));

/* File: bench/tb_pscl_strap_latch.sv */
// Self-checking bench for the strap latch with a board model.
// Assumes one 100 MHz clock and the AHB-Lite slave of the design.
`timescale 1ns/1ns
module tb_pscl_strap_latch;
  // --------------------------------------------------------------------
  // Signals, design and board
  // --------------------------------------------------------------------
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, sv;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, detach_mode, speed_100, duplex_half;
  logic autoneg_enable;
  logic [31:0] hrdata;
  logic [9:0] strap_in, strap_out, strap_oe_n, s, cfg = 10'h381;
  logic [2:0] station_addr;
  logic [1:0] iface_mode;
  int num_errors = 0, total_checks = 0;
  always #5 hclk = ~hclk;

  pscl_strap_latch #(.STRAP_W(10)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .strap_in(strap_in), .strap_out(strap_out), .strap_oe_n(strap_oe_n),
    .station_addr(station_addr), .iface_mode(iface_mode),
    .detach_mode(detach_mode), .speed_100(speed_100),
    .duplex_half(duplex_half), .autoneg_enable(autoneg_enable));
  pscl_strap_board board (.strap_level(cfg), .strap_out(strap_out),
    .strap_oe_n(strap_oe_n), .strap_in(strap_in));

  // --------------------------------------------------------------------
  // Expectations, checks and bus tasks
  // --------------------------------------------------------------------
  function automatic logic [2:0] fadr(input logic [2:0] a);
    return (a == 3'h0) ? 3'h1 : a;
  endfunction
  function automatic logic [1:0] fmode(input logic [2:0] c);
    return (c == 3'h0) ? 2'h0 : (c == 3'h1) ? 2'h1 : (c == 3'h4) ? 2'h2 : 2'h3;
  endfunction
  function automatic logic [31:0] fctrl(input logic [9:0] v);
    return {18'h0, v[7], v[9], 1'b0, v[6], 1'b0, v[8], 8'h00};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    for (int n = 0; n < 16; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) begin
        rd = hrdata;
        return;
      end
    end
    num_errors++;
    $display("Error at %0t: bus hang", $time);
    end_of_test();
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic reset_dut(input int n, input logic [9:0] v);
    @(posedge hclk);
    cfg <= v;
    hresetn <= 1'b0;
    repeat (n) @(posedge hclk);
    check(strap_oe_n, 10'h3FF);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic check_cfg(input logic [9:0] v);
    check(station_addr, fadr(v[2:0]));
    check(iface_mode, fmode(v[5:3]));
    check(detach_mode, v[6]);
    check(speed_100, v[7]);
    check(duplex_half, v[8]);
    check(autoneg_enable, v[9]);
    check(strap_oe_n, 10'h000);
    bus(1'b0, 12'h000, 0);
    check(rd, fctrl(v));
    bus(1'b0, 12'h004, 0);
    check(rd, v[7] ? 32'h01E1 : 32'h0061);
    bus(1'b0, 12'h008, 0);
    check(rd, {23'h0, 1'b1, fmode(v[5:3]), v[5:3], fadr(v[2:0])});
    check(hresp, 1'b0);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(56353));
    reset_dut(15, 10'h381);
    check_cfg(10'h381);
    $display("test default straps done");
    for (int i = 0; i < 8; i++) begin
      s = {4'($urandom), 3'(i), 3'(i)};
      if (i == 1) s[9:6] = 4'h0;
      if (i == 6) s[9:6] = 4'hF;
      reset_dut(3, s);
      check_cfg(s);
      cfg <= ~s;
      repeat (4) @(posedge hclk);
      @(negedge hclk);
      check(station_addr, fadr(s[2:0]));
      $display("test strap set %0d done", i);
    end
    bus(1'b1, 12'h000, 32'h0000_0400);
    @(negedge hclk);
    check(detach_mode, 1'b1);
    check(speed_100, 1'b0);
    bus(1'b0, 12'h000, 0);
    check(rd, 32'h0000_0400);
    bus(1'b1, 12'h000, 32'hFFFF_FFFF);
    bus(1'b0, 12'h000, 0);
    check(rd, 32'h0000_3500);
    bus(1'b0, 12'h008, 0);
    sv = rd;
    bus(1'b1, 12'h008, 32'hFFFF_FFFF);
    bus(1'b0, 12'h008, 0);
    check(rd, sv);
    bus(1'b1, 12'h010, 32'hFFFF_FFFF);
    bus(1'b0, 12'h010, 0);
    check(rd, 32'h0);
    bus(1'b1, 12'h00C, 32'h0000_02A5);
    @(negedge hclk);
    check(strap_out, 10'h2A5);
    check(strap_in, 10'h2A5);
    $display("test software access done");
    end_of_test();
  end
endmodule // tb_pscl_strap_latch
